// file: rtl/csic_top.sv
// Purpose: Clock speed selection, idle and power-down control, warm reset handling
// Assumes: Classic Wishbone slave; reset pin is asynchronous to clk_i
// Notes: Reset pin is open style: rst_pin_oe_n_o low while the block drives it
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module csic_top (
  input wire logic clk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [csic_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [csic_pkg::WB_DATA_W-1:0] wb_dat_i,
  output logic [csic_pkg::WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // System events
  input wire logic irq_i,
  input wire logic internal_reset_i,
  input wire logic wdt_fire_i,
  input wire logic adc_idle_mode_i,
  input wire logic adc_done_i,
  input wire logic [1:0] serial_mode_i,
  // Reset pin
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  // Clock enables and status
  output logic cpu_strobe_o,
  output logic [6:0] periph_strobe_o,
  output logic idle_o,
  output logic power_down_o,
  output logic warm_reset_o,
  output logic ram_block_o
);
  import csic_pkg::*;

  localparam logic [6:0] WDT_LAST = 7'(WDT_PULSE_CYC - 1);
  localparam logic [4:0] WARM_CNT = 5'(WARM_RESET_CYC);

  csic_clk_if clk_bus ();                 // Link to the strobe generator

  logic [7:0] clock_divider_control_q;    // Clock control byte
  logic [1:0] general_flags_q;            // General flag one and zero
  csic_pm_e mode_q;                       // Power state
  logic adc_idle_q;                       // Idle was started by converter
  logic half_q;                           // Half-rate oscillator phase
  logic x2_eff_q;                         // CPU speed bit as validated
  logic [2:0] pin_sync_q;                 // Reset pin synchroniser
  logic pin_level_q;                      // Filtered reset pin level
  logic [4:0] warm_cnt_q;                 // High-time counter on reset pin
  logic pin_warm;                         // Pin held long enough
  logic warm_reset_q;                     // Warm reset active
  logic [6:0] wdt_cnt_q;                  // Watchdog pulse counter
  logic wdt_drive_q;                      // Driving reset pin
  logic ram_block_q;                      // RAM locked out
  logic ack_q;                            // Bus answer
  logic [WB_DATA_W-1:0] dat_q;            // Read data
  logic req;                              // New bus request
  logic wr_power;                         // Write to power control
  logic wr_clock;                         // Write to clock control
  logic idle_exit;                        // Any cause that ends idle
  logic pd_exit;                          // Any cause that ends power-down
  logic [7:0] power_ctrl_rd;              // Power control as read
  logic serial_x2_ok;                     // Serial mode honours its speed bit

  // Bus decode; a write lands at the edge that samples ack, while the master still holds it
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_clock = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0] & (wb_adr_i == CLOCK_CTRL_ADDR);
  assign wr_power = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0] & (wb_adr_i == POWER_CTRL_ADDR);

  // Power control as seen by software; request bits reflect the state
  always_comb begin
    power_ctrl_rd = 8'h00;
    power_ctrl_rd[PC_IDLE_BIT] = (mode_q == PM_IDLE); // R19
    power_ctrl_rd[PC_PDOWN_BIT] = (mode_q == PM_POWER_DOWN); // R19
    power_ctrl_rd[PC_GF0_BIT] = general_flags_q[0];
    power_ctrl_rd[PC_GF1_BIT] = general_flags_q[1];
  end

  // Answer every request one cycle later, mapped or not
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dat_q <= '0;
    end else if (req & ~wb_we_i) begin
      if (wb_adr_i == CLOCK_CTRL_ADDR) begin
        dat_q <= {24'h000000, clock_divider_control_q};
      end else if (wb_adr_i == POWER_CTRL_ADDR) begin
        dat_q <= {24'h000000, power_ctrl_rd};
      end else begin
        dat_q <= '0;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Clock control byte, cleared by power-on and warm reset
  always_ff @(posedge clk_i) begin
    if (reset_i | warm_reset_q) begin
      clock_divider_control_q <= CLOCK_CTRL_RESET; // R5
    end else if (wr_clock) begin
      clock_divider_control_q <= wb_dat_i[7:0]; // R4
    end
  end

  // General flags are plain storage, untouched by idle
  always_ff @(posedge clk_i) begin
    if (reset_i | warm_reset_q) begin
      general_flags_q <= GENERAL_FLAGS_RESET;
    end else if (wr_power) begin
      general_flags_q <= {wb_dat_i[PC_GF1_BIT], wb_dat_i[PC_GF0_BIT]}; // R18
    end
  end

  // Half-rate oscillator phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // CPU speed bit taken over only as the half-rate clock rises
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      x2_eff_q <= 1'b0;
    end else if (~half_q) begin
      x2_eff_q <= clock_divider_control_q[CK_CPU_BIT]; // R20
    end
  end

  // Serial speed bit only counts in modes 0 and 2
  assign serial_x2_ok = ~serial_mode_i[0]; // R6

  // Per-channel speed selection
  always_comb begin
    clk_bus.fast = 8'h00;
    clk_bus.fast[0] = x2_eff_q; // R1
    for (int i = 1; i < 8; i++) begin
      clk_bus.fast[i] = x2_eff_q & ~clock_divider_control_q[i]; // R2 R3
    end
    clk_bus.fast[CK_SERIAL_BIT] = x2_eff_q & serial_x2_ok & ~clock_divider_control_q[CK_SERIAL_BIT]; // R6
  end

  // Freezing: idle stops the CPU only, power-down stops everything
  assign clk_bus.halt_cpu = (mode_q == PM_IDLE); // R10
  assign clk_bus.halt_all = (mode_q == PM_POWER_DOWN);

  csic_strobe_gen u_strobe_gen (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clk_bus(clk_bus)
  );

  assign cpu_strobe_o = clk_bus.strobe[0];
  assign periph_strobe_o = clk_bus.strobe[7:1];

  // Reset pin synchroniser, three stages
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], rst_pin_i};
    end
  end

  // Pin level changes once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_level_q <= 1'b0;
    end else if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_level_q <= pin_sync_q[2];
    end
  end

  // Count high time on the pin in oscillator periods, whatever the speed
  always_ff @(posedge clk_i) begin
    if (reset_i | ~pin_level_q) begin
      warm_cnt_q <= 5'h00;
    end else if (warm_cnt_q != WARM_CNT) begin
      warm_cnt_q <= warm_cnt_q + 5'h01; // R7
    end
  end

  assign pin_warm = (warm_cnt_q == WARM_CNT); // R7

  // Warm reset from a qualified pin or an internal source
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      warm_reset_q <= 1'b0;
    end else begin
      warm_reset_q <= pin_warm | internal_reset_i; // R8
    end
  end

  assign warm_reset_o = warm_reset_q;

  // Watchdog pulse counter; a new fire during a pulse is ignored
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_drive_q <= 1'b0;
      wdt_cnt_q <= 7'h00;
    end else if (~wdt_drive_q) begin
      wdt_drive_q <= wdt_fire_i; // R9
      wdt_cnt_q <= 7'h00;
    end else if (wdt_cnt_q == WDT_LAST) begin
      wdt_drive_q <= 1'b0;
      wdt_cnt_q <= 7'h00;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 7'h01; // R9
    end
  end

  assign rst_pin_o = wdt_drive_q;
  assign rst_pin_oe_n_o = ~wdt_drive_q;

  // Exit causes; a high pin ends a halt before qualification completes
  assign idle_exit = irq_i | pin_level_q | (adc_idle_q & adc_done_i); // R13 R14 R17
  assign pd_exit = irq_i | pin_level_q;

  // Power state machine
  always_ff @(posedge clk_i) begin
    if (reset_i | warm_reset_q) begin
      mode_q <= PM_RUN;
    end else begin
      unique case (mode_q)
        PM_RUN: begin
          if (wr_power & wb_dat_i[PC_PDOWN_BIT]) begin
            mode_q <= PM_POWER_DOWN; // R12
          end else if (wr_power & wb_dat_i[PC_IDLE_BIT]) begin
            mode_q <= PM_IDLE; // R11
          end
        end
        PM_IDLE: begin
          if (idle_exit) begin
            mode_q <= PM_RUN; // R13 R14
          end
        end
        PM_POWER_DOWN: begin
          if (pd_exit) begin
            mode_q <= PM_RUN; // R12
          end
        end
      endcase
    end
  end

  // Remember whether idle was entered through the converter
  always_ff @(posedge clk_i) begin
    if (reset_i | warm_reset_q) begin
      adc_idle_q <= 1'b0;
    end else if ((mode_q == PM_RUN) & wr_power & wb_dat_i[PC_IDLE_BIT]) begin
      adc_idle_q <= adc_idle_mode_i & ~wb_dat_i[PC_PDOWN_BIT]; // R17
    end else if (mode_q == PM_RUN) begin
      adc_idle_q <= 1'b0;
    end
  end

  // RAM lockout from a pin-driven exit until the warm reset takes over
  always_ff @(posedge clk_i) begin
    if (reset_i | warm_reset_q | ~pin_level_q) begin
      ram_block_q <= 1'b0;
    end else if (mode_q != PM_RUN) begin
      ram_block_q <= 1'b1; // R15
    end
  end

  assign ram_block_o = ram_block_q;
  assign idle_o = (mode_q == PM_IDLE);
  assign power_down_o = (mode_q == PM_POWER_DOWN);

  // Warm reset needs the pin high for the full count
  AST_WARM_QUAL: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(pin_warm) |-> $past(pin_level_q, 24)) // R7
    else $error("warm reset qualified too early");

  // Standard speed makes every channel slow
  AST_STD_ALL_SLOW: assert property (@(posedge clk_i) disable iff (reset_i)
    !x2_eff_q |-> (clk_bus.fast == 8'h00)) // R1 R3
    else $error("fast channel while CPU speed bit low");

  // Warm reset restores the control byte
  AST_WARM_CLEARS: assert property (@(posedge clk_i) disable iff (reset_i)
    warm_reset_q |=> (clock_divider_control_q == CLOCK_CTRL_RESET) && (mode_q == PM_RUN)) // R5 R8
    else $error("warm reset left state behind");

  // Watchdog pulse lasts exactly 96 cycles
  AST_WDT_PULSE: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(wdt_drive_q) |-> ##95 wdt_drive_q ##1 !wdt_drive_q) // R9
    else $error("watchdog pulse length wrong");

  // CPU strobes stop while idle
  AST_IDLE_FREEZE: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode_q == PM_IDLE) && $past(mode_q == PM_IDLE) |-> !cpu_strobe_o) // R10
    else $error("CPU strobe during idle");

  // Interrupt in idle clears the idle bit next cycle
  AST_IRQ_EXIT: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode_q == PM_IDLE) && irq_i |=> (mode_q == PM_RUN)) // R13 R19
    else $error("interrupt did not end idle");

  // Both requests together give power-down
  AST_PD_PRIORITY: assert property (@(posedge clk_i) disable iff (reset_i || warm_reset_q)
    (mode_q == PM_RUN) && wr_power && wb_dat_i[PC_PDOWN_BIT] |=> (mode_q == PM_POWER_DOWN)) // R12
    else $error("power-down did not take precedence");

  // Speed bit changes only on a half-rate rising edge
  AST_X2_HALF_EDGE: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(x2_eff_q) |-> $past(half_q) == 1'b0) // R20
    else $error("speed change off the half-rate edge");

  // Converter completion ends converter idle
  AST_ADC_EXIT: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode_q == PM_IDLE) && adc_idle_q && adc_done_i |=> (mode_q == PM_RUN)) // R17
    else $error("conversion did not end idle");

  // Idle entry takes effect right after the write
  AST_IDLE_ENTRY: assert property (@(posedge clk_i) disable iff (reset_i || warm_reset_q)
    (mode_q == PM_RUN) && wr_power && wb_dat_i[PC_IDLE_BIT] && !wb_dat_i[PC_PDOWN_BIT] |=> (mode_q == PM_IDLE)) // R11
    else $error("idle not entered after write");
endmodule : csic_top

// file: rtl/csic_pkg.sv
// Purpose: Shared constants for the clock speed and idle control block
// Assumes: clk_i is the oscillator itself, one clock edge per oscillator period
// Notes: Register byte address is four times the register index
//
// What this block does
// R1 - Speed bit low: all at 12 periods
// R2 - Peripheral bit clear 6 periods, set 12
// R3 - Peripheral bits act only with CPU speed set
// R4 - Control byte bit map, CPU speed bit 0
// R5 - Control byte resets to all zeros
// R6 - Serial speed bit only in modes 0, 2
// R7 - Warm reset needs 24 high periods, any mode
// R8 - Warm reset from pin or internal source
// R9 - Watchdog drives 96-period pulse on reset pin
// R10 - Idle freezes CPU, peripherals keep running
// R11 - Idle starts after the write setting it
// R12 - Both requests set gives power-down, never idle
// R13 - Enabled interrupt clears idle, CPU resumes
// R14 - Reset pin high clears idle at once
// R15 - RAM blocked between reset exit and reset
// R16 - Software avoids port writes after idle instruction
// R17 - Converter completion ends converter-started idle
// R18 - Two general flags are plain stored bits
// R19 - Idle bit 0, power-down bit 1, hardware cleared
// R20 - CPU speed change only on half-rate rising edge
// R21 - Peripheral clocks are strobes every 6 or 12
package csic_pkg;
  // Bus geometry
  localparam int unsigned WB_ADDR_W = 12;
  localparam int unsigned WB_DATA_W = 32;
  // Register indices and byte addresses
  localparam logic [7:0] CLOCK_CTRL_IDX = 8'h8F;
  localparam logic [7:0] POWER_CTRL_IDX = 8'h87;
  localparam logic [WB_ADDR_W-1:0] CLOCK_CTRL_ADDR = {2'b00, CLOCK_CTRL_IDX, 2'b00};
  localparam logic [WB_ADDR_W-1:0] POWER_CTRL_ADDR = {2'b00, POWER_CTRL_IDX, 2'b00};
  // Clock control byte fields
  localparam int unsigned CK_CPU_BIT = 0;
  localparam int unsigned CK_TIMER0_BIT = 1;
  localparam int unsigned CK_TIMER1_BIT = 2;
  localparam int unsigned CK_TIMER2_BIT = 3;
  localparam int unsigned CK_SERIAL_BIT = 4;
  localparam int unsigned CK_COUNTER_BIT = 5;
  localparam int unsigned CK_WATCHDOG_BIT = 6;
  localparam int unsigned CK_CAN_BIT = 7;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  // Power control byte fields
  localparam int unsigned PC_IDLE_BIT = 0;
  localparam int unsigned PC_PDOWN_BIT = 1;
  localparam int unsigned PC_GF0_BIT = 2;
  localparam int unsigned PC_GF1_BIT = 3;
  localparam logic [1:0] GENERAL_FLAGS_RESET = 2'h0;
  // Timing, in oscillator periods and nanoseconds
  localparam int unsigned OSC_PERIOD_NS = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned STD_PERIODS = 12;
  localparam int unsigned X2_PERIODS = 6;
  localparam int unsigned WARM_RESET_PERIODS = 24;
  localparam int unsigned WDT_PULSE_PERIODS = 96;
  localparam int unsigned STD_CYC = (STD_PERIODS * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int unsigned X2_CYC = (X2_PERIODS * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int unsigned WARM_RESET_CYC = (WARM_RESET_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDT_PULSE_CYC = (WDT_PULSE_PERIODS * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  // Channel count: CPU plus seven peripherals
  localparam int unsigned N_CH = 8;
  // Power states
  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_POWER_DOWN
  } csic_pm_e;
endpackage : csic_pkg

// file: rtl/csic_clk_if.sv
// Purpose: Carries speed selections and strobes between control and generator
// Assumes: One clock domain
// Notes: Channel 0 is the CPU, channel n is clock control bit n
`timescale 1ns/1ps
interface csic_clk_if;
  logic [7:0] fast;     // Channel uses 6 periods when high
  logic halt_cpu;       // Freeze CPU channel
  logic halt_all;       // Freeze every channel
  logic [7:0] strobe;   // One-cycle clock enables
  modport gen (input fast, input halt_cpu, input halt_all, output strobe);
  modport ctl (output fast, output halt_cpu, output halt_all, input strobe);
endinterface : csic_clk_if

// file: rtl/csic_strobe_gen.sv
// Purpose: Makes one clock-enable strobe per channel, every 6 or 12 periods
// Assumes: Selections come from the control block on the same clock
// Notes: A halted channel holds its counter, so it resumes at a known phase
`timescale 1ns/1ps
module csic_strobe_gen (
  input wire logic clk_i,
  input wire logic reset_i,
  csic_clk_if.gen clk_bus
);
  import csic_pkg::*;

  localparam logic [3:0] STD_LAST = 4'(STD_CYC - 1);
  localparam logic [3:0] X2_LAST = 4'(X2_CYC - 1);

  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++) begin : g_ch
      logic [3:0] cnt_q;   // Period counter
      logic strobe_q;      // Registered strobe
      logic halt;          // Channel frozen
      logic [3:0] last;    // Last count of the period
      assign halt = clk_bus.halt_all | ((ch == 0) & clk_bus.halt_cpu);
      assign last = clk_bus.fast[ch] ? X2_LAST : STD_LAST;
      // Counter wraps at the selected period and freezes while halted
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          cnt_q <= 4'h0;
        end else if (halt) begin
          cnt_q <= cnt_q;
        end else if (cnt_q >= last) begin
          cnt_q <= 4'h0; // R21
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
      // Strobe once per period, never while halted
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          strobe_q <= 1'b0;
        end else begin
          strobe_q <= ~halt & (cnt_q >= last); // R21
        end
      end
      assign clk_bus.strobe[ch] = strobe_q;
      // A fast channel strobes no more than once in six cycles
      AST_STROBE_SPACING: assert property (@(posedge clk_i) disable iff (reset_i)
        strobe_q |=> !strobe_q [*5]) // R21
        else $error("strobe repeated within six cycles");
    end
  endgenerate
endmodule : csic_strobe_gen

// file: sim/csic_periph_model.sv
// Purpose: Peripheral and CPU side model that times every clock-enable strobe
// Assumes: Channel 0 is the CPU, channel n follows clock control bit n
// Notes: Age saturates, so a frozen channel shows a large value
`timescale 1ns/1ps
module csic_periph_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] strobe_i,
  output logic [7:0][7:0] age_o,
  output logic [7:0][7:0] period_o
);
  // Each channel counts cycles since its last enable and keeps the last gap
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (reset_i) begin
        age_o[i] <= 8'h00;
        period_o[i] <= 8'h00;
      end else if (strobe_i[i]) begin
        // Gap between two enables, in oscillator periods
        period_o[i] <= age_o[i] + 8'h01;
        age_o[i] <= 8'h00;
      end else if (age_o[i] != 8'hFF) begin
        age_o[i] <= age_o[i] + 8'h01;
      end
    end
  end
endmodule : csic_periph_model

// file: sim/csic_tb.sv
// Purpose: Self-checking bench for clock speed, idle and warm reset control
// Assumes: Wishbone answers in its own time; reset pin is a wired level
// Notes: Expected periods come from the control byte and the serial mode
`timescale 1ns/1ps
module tb;
  import csic_pkg::*;
  logic clk_i, reset_i, wb_cyc, wb_stb, wb_we;
  logic [WB_ADDR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [WB_DATA_W-1:0] wb_dat, wb_dat_o, rd;
  logic wb_ack_o, irq_i, internal_reset_i, wdt_fire_i, adc_idle_mode_i, adc_done_i;
  logic [1:0] serial_mode_i;
  logic ext_pin, rst_pin_o, rst_pin_oe_n_o, cpu_strobe_o, idle_o, power_down_o, warm_reset_o, ram_block_o;
  logic [6:0] periph_strobe_o;
  logic [7:0][7:0] age, period;
  logic [7:0] cks [8] = '{8'h00, 8'h01, 8'hFF, 8'hFE, 8'h01, 8'h01, 8'hAB, 8'h55};
  logic [1:0] modes [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic fast, w;
  logic [3:0] sel; // Byte select for the next bus cycle
  int bad_count, comparisons, n;
  wire logic rst_pin_w = ext_pin | (~rst_pin_oe_n_o & rst_pin_o); // Wired reset pin level
  csic_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_i(irq_i), .internal_reset_i(internal_reset_i), .wdt_fire_i(wdt_fire_i),
    .adc_idle_mode_i(adc_idle_mode_i), .adc_done_i(adc_done_i), .serial_mode_i(serial_mode_i),
    .rst_pin_i(rst_pin_w), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
    .cpu_strobe_o(cpu_strobe_o), .periph_strobe_o(periph_strobe_o), .idle_o(idle_o),
    .power_down_o(power_down_o), .warm_reset_o(warm_reset_o), .ram_block_o(ram_block_o));
  csic_periph_model model_u (.clk_i(clk_i), .reset_i(reset_i), .strobe_i({periph_strobe_o, cpu_strobe_o}),
    .age_o(age), .period_o(period));
  // Verdict and end of run
  task results;
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // Compare one value
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Classic Wishbone single cycle; ack and read data are taken at the rising edge that samples ack high
  task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] dat);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel;
    wb_adr <= adr;
    wb_dat <= {24'h000000, dat};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      results();
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  // Select an observed status output
  function automatic logic sig(input int k);
    case (k)
      0: return idle_o;
      1: return power_down_o;
      2: return warm_reset_o;
      3: return ram_block_o;
      default: return rst_pin_oe_n_o;
    endcase
  endfunction : sig
  // Bounded wait for a status level; running out ends the run
  task automatic wait_val(input string name, input int k, input logic v, input int lim);
    int j;
    j = 0;
    do begin
      @(posedge clk_i);
      j++;
    end while (sig(k) !== v && j < lim);
    chk(name, sig(k), v);
    if (sig(k) !== v) begin
      results();
    end
  endtask : wait_val
  // Oscillator at 125 MHz
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    {reset_i, wb_cyc, wb_stb, wb_we, irq_i, internal_reset_i, wdt_fire_i} = 7'h40;
    {adc_idle_mode_i, adc_done_i, ext_pin} = 3'h0;
    {wb_adr, wb_dat, serial_mode_i} = '0;
    wb_sel = 4'h1;
    sel = 4'h1;
    bad_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    wb(1'b0, CLOCK_CTRL_ADDR, 8'h00);
    chk("clock_ctrl reset", rd, 32'h00000000);
    wb(1'b0, POWER_CTRL_ADDR, 8'h00);
    chk("power_ctrl reset", rd, 32'h00000000);
    wb(1'b1, 12'h100, 8'hFF);
    wb(1'b0, 12'h100, 8'h00);
    chk("unmapped", rd, 32'h00000000);
    wb(1'b1, CLOCK_CTRL_ADDR, 8'hA5);
    sel = 4'h0;
    wb(1'b1, CLOCK_CTRL_ADDR, 8'h5A);
    sel = 4'h1;
    wb(1'b0, CLOCK_CTRL_ADDR, 8'h00);
    chk("clock_ctrl rw", rd, 32'h000000A5);
    // Strobe spacing for every channel over a table of settings
    for (int c = 0; c < 8; c++) begin
      serial_mode_i <= modes[c];
      wb(1'b1, CLOCK_CTRL_ADDR, cks[c]);
      repeat (50) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        fast = cks[c][0] && (i == 0 || (!cks[c][i] && !(i == 4 && modes[c][0])));
        chk("strobe period", period[i], fast ? 32'h06 : 32'h0C);
      end
    end
    // Idle with both flags; next access is a register read, never a port write
    wb(1'b1, POWER_CTRL_ADDR, 8'h0D);
    wait_val("idle entry", 0, 1'b1, 3);
    repeat (30) @(posedge clk_i);
    chk("cpu frozen", age[0] >= 8'h19, 32'h1);
    chk("periph running", age[1] < 8'h0D, 32'h1);
    adc_done_i <= 1'b1;
    @(posedge clk_i);
    adc_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("adc done ignored", idle_o, 1'b1);
    irq_i <= 1'b1;
    wait_val("irq exit", 0, 1'b0, 3);
    irq_i <= 1'b0;
    wb(1'b0, POWER_CTRL_ADDR, 8'h00);
    chk("flags kept", rd, 32'h0000000C);
    // Both requests: power-down, and no idle afterwards
    wb(1'b1, POWER_CTRL_ADDR, 8'h03);
    wait_val("power down", 1, 1'b1, 3);
    chk("no idle in pd", idle_o, 1'b0);
    irq_i <= 1'b1;
    wait_val("pd exit", 1, 1'b0, 3);
    irq_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("no idle after pd", idle_o, 1'b0);
    // Converter idle ends on conversion done
    adc_idle_mode_i <= 1'b1;
    wb(1'b1, POWER_CTRL_ADDR, 8'h01);
    adc_idle_mode_i <= 1'b0;
    wait_val("adc idle", 0, 1'b1, 3);
    adc_done_i <= 1'b1;
    @(posedge clk_i);
    adc_done_i <= 1'b0;
    wait_val("adc exit", 0, 1'b0, 3);
    // Short pin pulse is no warm reset
    @(posedge clk_i);
    ext_pin <= 1'b1;
    repeat (15) @(posedge clk_i);
    ext_pin <= 1'b0;
    w = 1'b0;
    repeat (40) begin
      @(posedge clk_i);
      w = w | warm_reset_o;
    end
    chk("short pin", w, 1'b0);
    // Pin high during idle: prompt exit, RAM lockout, then warm reset
    wb(1'b1, CLOCK_CTRL_ADDR, 8'h01);
    wb(1'b1, POWER_CTRL_ADDR, 8'h01);
    wait_val("idle again", 0, 1'b1, 3);
    ext_pin <= 1'b1;
    wait_val("pin exit", 0, 1'b0, 6);
    wait_val("ram blocked", 3, 1'b1, 3);
    wait_val("warm from pin", 2, 1'b1, 30);
    wait_val("ram free", 3, 1'b0, 3);
    ext_pin <= 1'b0;
    wait_val("warm end", 2, 1'b0, 30);
    wb(1'b0, CLOCK_CTRL_ADDR, 8'h00);
    chk("clock_ctrl warm", rd, 32'h00000000);
    // Internal source
    wb(1'b1, CLOCK_CTRL_ADDR, 8'h01);
    internal_reset_i <= 1'b1;
    @(posedge clk_i);
    internal_reset_i <= 1'b0;
    wait_val("warm internal", 2, 1'b1, 3);
    wait_val("warm internal end", 2, 1'b0, 30);
    wb(1'b0, CLOCK_CTRL_ADDR, 8'h00);
    chk("clock_ctrl internal", rd, 32'h00000000);
    // Watchdog pin pulse length
    @(posedge clk_i);
    wdt_fire_i <= 1'b1;
    @(posedge clk_i);
    wdt_fire_i <= 1'b0;
    wait_val("pin drive", 4, 1'b0, 3);
    chk("pin level", rst_pin_o, 1'b1);
    n = 0;
    while (rst_pin_oe_n_o === 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("pulse length", n, 32'd96);
    results();
  end
endmodule : tb
